//--- common/phcb_pkg.sv
// Shared constants and types for the host/PCI channel bridge ends
package phcb_pkg;
    // ==================== Host I/O window ====================
    localparam logic [39:0] HOST_WIN_LO   = 40'hf800000000;
    localparam logic [39:0] HOST_WIN_HI   = 40'hfbffffffff;
    localparam int          HUB_SEL_MSB   = 8;    // 40-bit MSB0 bits 6:8
    localparam int          UNIT_MSB      = 10;   // MSB0 bits 9:10
    localparam int          OFFSET_W      = 29;
    // ==================== Config fields (MSB0 numbering) ====================
    localparam int          BUS_FIRST     = 16;
    localparam int          DEV_FIRST     = 24;
    localparam int          FUNC_FIRST    = 29;
    localparam int          REG_FIRST     = 32;
    localparam int          BYTE_FIRST    = 38;
    localparam logic [4:0]  BUS0_DEV_MAX  = 5'h03;
    // ==================== Channel layout ====================
    localparam int          CHAN_W        = 10;
    localparam int          CHAN_OFF_W    = 22;
    localparam logic [9:0]  CHAN_RSV_LO   = 10'h3f0;
    localparam logic [9:0]  CHAN_SRAM     = 10'h3ff;
    localparam int          PHYS_BASE_W   = 18;
    localparam int          LINE_BYTES    = 32;
    localparam int          STEP_CHANS    = 16;
    localparam int          SPLIT_W       = 6;    // 64 MB steps over 4 GB
    // ==================== Context SRAM ====================
    localparam logic [20:0] CTX_BYTES     = 21'h010000;
    localparam logic [20:0] SRAM_MIN      = 21'h040000;
    localparam logic [20:0] SRAM_MAX      = 21'h1fffff;
    localparam logic [31:0] PCI_IO_BASE   = 32'h00000000;
    localparam logic [31:0] PCI_MEM_TOP   = 32'hffbfffff;
    // ==================== Codes ====================
    typedef enum logic [1:0] {PHCB_CFG, PHCB_IO, PHCB_MEM, PHCB_NONE} phcb_space_t;
    typedef enum logic [1:0] {PHCB_SZ1, PHCB_SZ2, PHCB_SZ4, PHCB_SZ8} phcb_size_t;
    typedef enum logic [1:0] {PHCB_TGT_SYS, PHCB_TGT_CTX, PHCB_TGT_SHR, PHCB_TGT_ERR}
        phcb_tgt_t;
endpackage : phcb_pkg

//--- common/phcb_if.sv
// Link between the bridge core and the host/PCI agent
`timescale 1ns/100ps
interface phcb_if;
    // Host I/O request, agent to bridge
    logic        h_req;
    logic        h_wr;
    logic [39:0] h_addr;
    logic [1:0]  h_size;
    logic [31:0] h_wdata;
    // PCI cycle out, bridge to agent
    logic        p_cyc;
    logic [1:0]  p_space;
    logic [31:0] p_addr;
    logic [3:0]  p_be;
    logic        p_err;
    // PCI memory access in, agent to bridge
    logic        m_req;
    logic        m_wr;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    // Translation answer, bridge to agent
    logic        t_vld;
    logic [39:0] t_addr;
    logic [1:0]  t_tgt;
    logic        t_err;
    logic        t_flush;
    logic [255:0] t_line;
    modport bridge (input h_req, h_wr, h_addr, h_size, h_wdata, m_req, m_wr, m_addr, m_wdata,
                    output p_cyc, p_space, p_addr, p_be, p_err,
                    output t_vld, t_addr, t_tgt, t_err, t_flush, t_line);
    modport agent (output h_req, h_wr, h_addr, h_size, h_wdata, m_req, m_wr, m_addr, m_wdata,
                   input p_cyc, p_space, p_addr, p_be, p_err,
                   input t_vld, t_addr, t_tgt, t_err, t_flush, t_line);
endinterface : phcb_if

//--- core/phcb_bridge.sv
// Bridge core: host I/O decode, PCI channel translation, channel builder
`timescale 1ns/100ps
module phcb_bridge #(
    parameter int          NCHAN     = 1008,
    parameter logic [20:0] SRAM_SIZE = 21'h040000
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Link
    phcb_if.bridge           lnk,
    // Identity straps of this bridge
    input  wire logic [2:0]  my_hub,
    input  wire logic [1:0]  my_unit,
    // Software register port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [31:0]      sw_rdata
);
    // ==================== Register map ====================
    localparam logic [3:0] R_BUILD  = 4'h0;  // [9:0] chan, [10] xlate en, [28:11] base
    localparam logic [3:0] R_SPLIT  = 4'h1;  // [5:0] I/O steps of 64 MB
    localparam logic [3:0] R_STATUS = 4'h2;
    localparam logic [3:0] R_AVAIL  = 4'h3;

    function automatic logic [7:0] be_of(input logic [1:0] lane, input logic [1:0] sz);
        logic [7:0] m;
        m = (sz == 2'(phcb_pkg::PHCB_SZ1)) ? 8'h01 : (sz == 2'(phcb_pkg::PHCB_SZ2)) ? 8'h03 : 8'h0f;
        return m << lane;
    endfunction : be_of

    // ==================== Channel context ====================
    logic [17:0] base_mem [NCHAN];
    logic        xlate_en [NCHAN];
    logic        built    [NCHAN];
    logic [5:0]  split_reg;
    logic [9:0]  last_chan_reg;
    logic [7:0]  err_cnt_reg;

    // ==================== Host decode ====================
    wire logic [39:0] ha   = lnk.h_addr;
    wire logic        in_win = (ha >= phcb_pkg::HOST_WIN_LO) && (ha <= phcb_pkg::HOST_WIN_HI);
    wire logic [2:0]  hub  = ha[39-6 -: 3];
    wire logic [1:0]  unit = ha[39-9 -: 2];
    wire logic [28:0] hoff = ha[28:0];
    wire logic        mine = in_win && hub == my_hub && unit == my_unit;
    // Offset top two bits select space: 00 config, 01 I/O, 1x memory
    wire logic        is_cfg = mine && hoff[28:27] == 2'b00;
    wire logic        is_io  = mine && hoff[28:27] == 2'b01;
    wire logic        is_mem = mine && hoff[28];
    wire logic [7:0]  c_bus  = ha[39-phcb_pkg::BUS_FIRST -: 8];
    wire logic [4:0]  c_dev  = ha[39-phcb_pkg::DEV_FIRST -: 5];
    wire logic [2:0]  c_fn   = ha[39-phcb_pkg::FUNC_FIRST -: 3];
    wire logic [5:0]  c_reg  = ha[39-phcb_pkg::REG_FIRST -: 6];
    wire logic [1:0]  c_byte = ha[39-phcb_pkg::BYTE_FIRST -: 2];
    wire logic        bad_dev = c_bus == 8'h00 && c_dev > phcb_pkg::BUS0_DEV_MAX;
    wire logic        misal  = (lnk.h_size == 2'(phcb_pkg::PHCB_SZ2) && ha[0]) ||
                               (lnk.h_size == 2'(phcb_pkg::PHCB_SZ4) && ha[1:0] != 2'b00);
    wire logic        sz64   = lnk.h_size == 2'(phcb_pkg::PHCB_SZ8);
    // I/O occupies split*64 MB upward; memory takes the rest downward
    wire logic [31:0] io_lim = {split_reg, 26'h0000000};
    wire logic [31:0] io_a   = phcb_pkg::PCI_IO_BASE + {6'h00, hoff[25:0]};
    wire logic [31:0] mem_a  = phcb_pkg::PCI_MEM_TOP - {6'h00, hoff[25:0]};
    wire logic        io_oob = split_reg == 6'h00 || {6'h00, hoff[25:0]} >= io_lim;
    // Memory gets the steps that I/O does not have; a full split leaves none
    wire logic [31:0] mem_lim = {6'h3f - split_reg, 26'h0000000};
    wire logic        mem_oob = {6'h00, hoff[25:0]} >= mem_lim;
    logic [1:0]  sp_n;
    logic [31:0] pa_n;
    logic [3:0]  pbe_n;
    logic        perr_n;
    always_comb begin
        sp_n   = 2'(phcb_pkg::PHCB_NONE);
        pa_n   = 32'h00000000;
        pbe_n  = 4'h0;
        perr_n = sz64 || misal;
        if (is_cfg) begin
            sp_n  = 2'(phcb_pkg::PHCB_CFG);
            pa_n  = {8'h00, c_bus, c_dev, c_fn, c_reg, 2'b00};
            pbe_n = 4'(be_of(c_byte, lnk.h_size));
            perr_n = perr_n || bad_dev;
        end else if (is_io) begin
            sp_n  = 2'(phcb_pkg::PHCB_IO);
            pa_n  = io_a;
            pbe_n = 4'(be_of(io_a[1:0], lnk.h_size));
            perr_n = perr_n || io_oob;
        end else if (is_mem) begin
            sp_n  = 2'(phcb_pkg::PHCB_MEM);
            pa_n  = {mem_a[31:2], 2'b00};
            // Words count down, lanes inside a word still follow the host offset
            pbe_n = 4'(be_of(hoff[1:0], lnk.h_size));
            perr_n = perr_n || mem_oob;
        end
    end

    // ==================== PCI-side translation ====================
    wire logic [9:0]  chan  = lnk.m_addr[31 -: phcb_pkg::CHAN_W];
    wire logic [21:0] coff  = lnk.m_addr[phcb_pkg::CHAN_OFF_W-1:0];
    // Memory split steals channels from the top of the usable range
    wire logic [9:0]  avail = 10'(NCHAN) - 10'(phcb_pkg::STEP_CHANS) *
                              (6'h3f - split_reg);
    wire logic        rsv   = chan >= phcb_pkg::CHAN_RSV_LO;
    wire logic        is_sram = chan == phcb_pkg::CHAN_SRAM;
    wire logic [20:0] s_off = coff[20:0];
    wire logic        s_ctx = s_off < phcb_pkg::CTX_BYTES;
    wire logic        s_oob = coff[21] || s_off >= SRAM_SIZE;
    wire logic [9:0]  ci    = rsv ? 10'h000 : chan;
    wire logic        c_ok  = !rsv && chan < avail && built[ci];
    wire logic [39:0] sys_a = {base_mem[ci], coff};
    logic [1:0]  tt_n;
    logic        terr_n;
    always_comb begin
        tt_n   = 2'(phcb_pkg::PHCB_TGT_SYS);
        terr_n = 1'b0;
        if (is_sram) begin
            // Context reads/writes here are a diagnostic path only
            tt_n   = s_ctx ? 2'(phcb_pkg::PHCB_TGT_CTX) : 2'(phcb_pkg::PHCB_TGT_SHR);
            terr_n = s_oob;
        end else if (!c_ok || !xlate_en[ci]) begin
            // Logical mode tables are outside this block
            tt_n   = 2'(phcb_pkg::PHCB_TGT_ERR);
            terr_n = 1'b1;
        end
    end

    // ==================== Posted write gather ====================
    logic [255:0] line_reg;
    logic [7:0]   line_fill_reg;
    logic [39:0]  line_addr_reg;
    wire logic    gather = lnk.m_req && lnk.m_wr && tt_n == 2'(phcb_pkg::PHCB_TGT_SYS) && !terr_n;
    wire logic [2:0] word = lnk.m_addr[4:2];
    // A write to another line drops the partial one rather than mixing lines
    wire logic [39:0] line_base = {sys_a[39:5], 5'h00};
    wire logic       same_line = line_addr_reg == line_base;
    wire logic [7:0] fill = (same_line ? line_fill_reg : 8'h00) | (8'h01 << word);
    // Offset crossing 4 MB moves to chan+1 only in software; hardware keeps lines in channel
    wire logic    full = gather && fill == 8'hff;

    // ==================== Sequential ====================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            split_reg <= 6'h3f;
            last_chan_reg <= 10'h000;
            err_cnt_reg <= 8'h00;
            line_fill_reg <= 8'h00;
            line_reg <= '0;
            line_addr_reg <= '0;
            lnk.p_cyc <= 1'b0; lnk.p_space <= 2'b11; lnk.p_addr <= '0;
            lnk.p_be <= 4'h0; lnk.p_err <= 1'b0;
            lnk.t_vld <= 1'b0; lnk.t_addr <= '0; lnk.t_tgt <= 2'b00; lnk.t_err <= 1'b0;
            lnk.t_flush <= 1'b0; lnk.t_line <= '0;
            sw_rdata <= 32'h00000000;
        end else begin
            lnk.p_cyc <= lnk.h_req && (is_cfg || is_io || is_mem);
            lnk.p_space <= sp_n; lnk.p_addr <= pa_n; lnk.p_be <= pbe_n; lnk.p_err <= perr_n;
            lnk.t_vld <= lnk.m_req; lnk.t_addr <= is_sram ? {19'h0, s_off} : sys_a;
            lnk.t_tgt <= tt_n; lnk.t_err <= terr_n;
            if ((lnk.m_req && terr_n) || (lnk.h_req && mine && perr_n))
                err_cnt_reg <= err_cnt_reg + 8'h01;
            lnk.t_flush <= full;
            if (gather) begin
                line_reg[word*32 +: 32] <= lnk.m_wdata;
                line_fill_reg <= full ? 8'h00 : fill;
                line_addr_reg <= line_base;
                if (full) begin
                    lnk.t_line <= line_reg;
                    lnk.t_line[word*32 +: 32] <= lnk.m_wdata;
                end
            end
            if (sw_wr && sw_addr == R_SPLIT) split_reg <= sw_wdata[5:0];
            if (sw_wr && sw_addr == R_BUILD) last_chan_reg <= sw_wdata[9:0];
            unique case (sw_addr)
                R_BUILD:  sw_rdata <= {22'h0, last_chan_reg};
                R_SPLIT:  sw_rdata <= {26'h0, split_reg};
                R_STATUS: sw_rdata <= {8'h00, err_cnt_reg, line_fill_reg, 5'h00, last_chan_reg[9:7]};
                R_AVAIL:  sw_rdata <= {22'h0, avail};
                default:  sw_rdata <= 32'h00000000;
            endcase
            if (!sw_rd) sw_rdata <= 32'h00000000;
        end
    end

    // Context array holds no reset; built flags clear at reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCHAN; i++) built[i] <= 1'b0;
        end else if (sw_wr && sw_addr == R_BUILD && sw_wdata[9:0] < 10'(NCHAN)) begin
            built[sw_wdata[9:0]] <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sw_wr && sw_addr == R_BUILD && sw_wdata[9:0] < 10'(NCHAN)) begin
            base_mem[sw_wdata[9:0]] <= sw_wdata[28:11];
            xlate_en[sw_wdata[9:0]] <= sw_wdata[10];
        end
    end
endmodule : phcb_bridge

//--- core/phcb_agent.sv
// Agent end: issues host I/O requests and PCI channel accesses
`timescale 1ns/100ps
module phcb_agent (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Link
    phcb_if.agent            lnk,
    // User host request
    input  wire logic        u_h_go,
    input  wire logic        u_h_wr,
    input  wire logic [39:0] u_h_addr,
    input  wire logic [1:0]  u_h_size,
    input  wire logic [31:0] u_h_wdata,
    // User PCI request
    input  wire logic        u_m_go,
    input  wire logic        u_m_wr,
    input  wire logic [31:0] u_m_addr,
    input  wire logic [31:0] u_m_wdata,
    // Results
    output logic             u_p_done,
    output logic [31:0]      u_p_addr,
    output logic [3:0]       u_p_be,
    output logic             u_p_err,
    output logic             u_t_done,
    output logic [39:0]      u_t_addr,
    output logic             u_t_err
);
    // ==================== Drive and capture ====================
    // Each user request goes out for one cycle; sharing a channel is the user's hazard
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.h_req <= 1'b0; lnk.h_wr <= 1'b0; lnk.h_addr <= '0;
            lnk.h_size <= 2'b00; lnk.h_wdata <= '0;
            lnk.m_req <= 1'b0; lnk.m_wr <= 1'b0; lnk.m_addr <= '0; lnk.m_wdata <= '0;
            u_p_done <= 1'b0; u_p_addr <= '0; u_p_be <= 4'h0; u_p_err <= 1'b0;
            u_t_done <= 1'b0; u_t_addr <= '0; u_t_err <= 1'b0;
        end else begin
            lnk.h_req <= u_h_go; lnk.h_wr <= u_h_wr; lnk.h_addr <= u_h_addr;
            lnk.h_size <= u_h_size; lnk.h_wdata <= u_h_wdata;
            lnk.m_req <= u_m_go; lnk.m_wr <= u_m_wr; lnk.m_addr <= u_m_addr;
            lnk.m_wdata <= u_m_wdata;
            u_p_done <= lnk.p_cyc; u_p_addr <= lnk.p_addr; u_p_be <= lnk.p_be;
            u_p_err <= lnk.p_err;
            u_t_done <= lnk.t_vld; u_t_addr <= lnk.t_addr;
            u_t_err <= lnk.t_err;
        end
    end
endmodule : phcb_agent

//--- tb/phcb_link_chk.sv
// Concurrent checks on the link between bridge core and agent end
`timescale 1ns/100ps
module phcb_link_chk #(
    parameter logic [20:0] SRAM_SIZE = 21'h040000
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Host request and PCI cycle
    input wire logic        h_req,
    input wire logic [39:0] h_addr,
    input wire logic [1:0]  h_size,
    input wire logic        p_cyc,
    input wire logic [1:0]  p_space,
    input wire logic [31:0] p_addr,
    input wire logic        p_err,
    // PCI access and translation
    input wire logic        m_req,
    input wire logic        m_wr,
    input wire logic [31:0] m_addr,
    input wire logic        t_vld,
    input wire logic [39:0] t_addr,
    input wire logic [1:0]  t_tgt,
    input wire logic        t_err,
    input wire logic        t_flush
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic [9:0]  m_chan = m_addr[31:22];
    wire logic        h_win  = h_addr >= phcb_pkg::HOST_WIN_LO && h_addr <= phcb_pkg::HOST_WIN_HI;
    // ==================================
    // Channel 1023 and reserved requests
    sequence s_ctx_req;
        m_req && m_chan == phcb_pkg::CHAN_SRAM && m_addr[21:0] < {1'b0, phcb_pkg::CTX_BYTES};
    endsequence
    sequence s_shr_req;
        m_req && m_chan == phcb_pkg::CHAN_SRAM && m_addr[21:0] >= {1'b0, phcb_pkg::CTX_BYTES}
            && m_addr[21:0] < {1'b0, SRAM_SIZE};
    endsequence
    sequence s_rsv_req;
        m_req && m_chan >= phcb_pkg::CHAN_RSV_LO && m_chan != phcb_pkg::CHAN_SRAM;
    endsequence
    a_trans_answer: assert property (m_req |=> t_vld)
        else $error("translation answer missing");
    a_trans_cause: assert property (t_vld |-> $past(m_req))
        else $error("translation without request");
    a_rsv_refused: assert property (s_rsv_req |=> t_vld && t_err)
        else $error("reserved channel accepted");
    a_offset_kept: assert property (t_vld && !t_err && t_tgt == phcb_pkg::PHCB_TGT_SYS
        |-> t_addr[21:0] == $past(m_addr[21:0])) else $error("channel offset altered");
    a_ctx_target: assert property (s_ctx_req |=> !t_err && t_tgt == phcb_pkg::PHCB_TGT_CTX)
        else $error("context window not reached");
    a_shr_target: assert property (s_shr_req |=> !t_err && t_tgt == phcb_pkg::PHCB_TGT_SHR)
        else $error("shared window not reached");
    a_flush_cause: assert property (t_flush |-> $past(m_req && m_wr))
        else $error("flush without write");
    a_host_window: assert property (p_cyc |-> $past(h_req && h_win))
        else $error("PCI cycle outside host window");
    a_cfg_fields: assert property (p_cyc && p_space == phcb_pkg::PHCB_CFG && !p_err
        |-> p_addr[23:0] == {$past(h_addr[23:2]), 2'b00}) else $error("config fields wrong");
    a_bus0_dev: assert property (h_req && h_addr[28:27] == 2'b00 && h_addr[23:16] == 8'h00
        && h_addr[15:11] > phcb_pkg::BUS0_DEV_MAX |=> !p_cyc || p_err) else $error("bus 0 dev");
    a_size8_err: assert property (h_req && h_size == phcb_pkg::PHCB_SZ8 |=> !p_cyc || p_err)
        else $error("8-byte access accepted");
    a_io_addr: assert property (p_cyc && p_space == phcb_pkg::PHCB_IO && !p_err
        |-> p_addr == {6'h00, $past(h_addr[25:0])}) else $error("I/O address wrong");
    a_mem_align: assert property (p_cyc && p_space == phcb_pkg::PHCB_MEM |-> p_addr[1:0] == 2'b00)
        else $error("memory address unaligned");
endmodule : phcb_link_chk

//--- tb/pci_host_channel_bridge_test.sv
// Self-checking bench joining bridge core and agent end
`timescale 1ns/100ps
module pci_host_channel_bridge_test;
    logic         ref_clk = 1'b0, rst_n = 1'b0;
    logic         u_h_go = 1'b0, u_h_wr = 1'b0, u_m_go = 1'b0, u_m_wr = 1'b0;
    logic [39:0]  u_h_addr = 40'h0, r_addr;
    logic [31:0]  u_h_wdata = 32'h0, u_m_addr = 32'h0, u_m_wdata = 32'h0, sw_wdata = 32'h0;
    logic [1:0]   u_h_size = 2'h0;
    logic [3:0]   sw_addr = 4'h0, u_p_be, r_be;
    logic         sw_wr = 1'b0, sw_rd = 1'b0, got, r_err, u_p_done, u_p_err, u_t_done, u_t_err;
    logic [31:0]  sw_rdata, u_p_addr, rd;
    logic [39:0]  u_t_addr;
    logic [255:0] flush_line;
    int           errors = 0, n_checks = 0, cycles = 0, n_flush = 0;
    phcb_if lnk ();
    phcb_bridge #(.NCHAN(1008), .SRAM_SIZE(21'h040000)) u_phcb_bridge (.ref_clk(ref_clk),
        .rst_n(rst_n), .lnk(lnk), .my_hub(3'h5), .my_unit(2'h2), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    phcb_agent u_phcb_agent (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .u_h_go(u_h_go),
        .u_h_wr(u_h_wr), .u_h_addr(u_h_addr), .u_h_size(u_h_size), .u_h_wdata(u_h_wdata),
        .u_m_go(u_m_go), .u_m_wr(u_m_wr), .u_m_addr(u_m_addr), .u_m_wdata(u_m_wdata),
        .u_p_done(u_p_done), .u_p_addr(u_p_addr), .u_p_be(u_p_be), .u_p_err(u_p_err),
        .u_t_done(u_t_done), .u_t_addr(u_t_addr), .u_t_err(u_t_err));
    phcb_link_chk #(.SRAM_SIZE(21'h040000)) u_phcb_link_chk (.ref_clk(ref_clk), .rst_n(rst_n),
        .h_req(lnk.h_req), .h_addr(lnk.h_addr), .h_size(lnk.h_size), .p_cyc(lnk.p_cyc),
        .p_space(lnk.p_space), .p_addr(lnk.p_addr), .p_err(lnk.p_err), .m_req(lnk.m_req),
        .m_wr(lnk.m_wr), .m_addr(lnk.m_addr), .t_vld(lnk.t_vld), .t_addr(lnk.t_addr),
        .t_tgt(lnk.t_tgt), .t_err(lnk.t_err), .t_flush(lnk.t_flush));
    always #2 ref_clk = ~ref_clk;
    // =====================================
    // Monitor and hang guard, run is short
    always @(posedge ref_clk) begin
        cycles++;
        if (lnk.t_flush === 1'b1) begin
            n_flush++;
            flush_line = lnk.t_line;
        end
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // Hub 5, unit 2 match the straps
    function automatic logic [39:0] ha(input logic [2:0] hub, input logic [28:0] off);
        return {6'b111110, hub, 2'h2, off};
    endfunction : ha
    // One host or PCI request, result captured from the one-cycle done pulse
    task automatic go(input logic pci, input logic wr, input logic [39:0] a, input logic [1:0] sz);
        @(posedge ref_clk);
        u_h_go    <= !pci;
        u_m_go    <= pci;
        u_h_wr    <= wr;
        u_m_wr    <= wr;
        u_h_addr  <= a;
        u_m_addr  <= a[31:0];
        u_h_size  <= sz;
        u_h_wdata <= a[31:0];
        u_m_wdata <= ~a[31:0];
        @(posedge ref_clk);
        u_h_go <= 1'b0;
        u_m_go <= 1'b0;
        got = 1'b0;
        repeat (5) begin
            @(posedge ref_clk);
            #1;
            if (u_p_done === 1'b1 || u_t_done === 1'b1) got = 1'b1;
            if (u_p_done === 1'b1) {r_addr, r_be, r_err} = {8'h00, u_p_addr, u_p_be, u_p_err};
            if (u_t_done === 1'b1) {r_addr, r_err} = {u_t_addr, u_t_err};
        end
    endtask : go
    task automatic sw(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        sw_wr    <= wr;
        sw_rd    <= !wr;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1;
        rd = sw_rdata;
    endtask : sw
    task automatic t_cfg();
        go(0, 0, ha(5, {5'h00, 8'h01, 5'h07, 3'h2, 6'h05, 2'h1}), 2'h0);
        chk({got, r_err, r_be}, 6'b10_0010, "cfg done/err/be");
        chk(r_addr[23:0], {8'h01, 5'h07, 3'h2, 6'h05, 2'b00}, "cfg addr");
        go(0, 0, ha(5, {5'h00, 8'h00, 5'h03, 9'h000, 2'h0}), 2'h2);
        chk({got, r_err}, 2'b10, "bus0 dev3");
        go(0, 0, ha(5, {5'h00, 8'h00, 5'h04, 9'h000, 2'h0}), 2'h2);
        chk(r_err, 1'b1, "bus0 dev4");
        go(0, 0, ha(5, 29'h000100), 2'h3);
        chk(r_err, 1'b1, "size 8");
        go(0, 1, ha(5, 29'h000101), 2'h1);
        chk(r_err, 1'b1, "misaligned");
        go(0, 0, ha(4, 29'h000100), 2'h2);
        chk(got, 1'b0, "other hub");
        go(0, 0, 40'hfc00000000, 2'h2);
        chk(got, 1'b0, "outside window");
    endtask : t_cfg
    task automatic t_split();
        sw(0, 4'h1, 0);
        chk(rd, 32'h3f, "split reset");
        sw(0, 4'h7, 0);
        chk(rd, 32'h0, "unmapped");
        go(0, 1, ha(5, {2'b01, 27'h105}), 2'h0);
        chk({r_err, r_be, r_addr[31:0]}, {5'b0_0010, 32'h105}, "io addr");
        go(0, 0, ha(5, {2'b10, 27'h0}), 2'h2);
        chk(r_err, 1'b1, "mem with all io");
        sw(1, 4'h1, 32'h3e);
        go(0, 0, ha(5, {2'b10, 27'h0}), 2'h2);
        chk({r_err, r_be, r_addr[31:0]}, {5'b0_1111, 32'hffbffffc}, "mem top");
        sw(0, 4'h3, 0);
        chk(rd, 32'd992, "chans one step");
        sw(1, 4'h1, 32'h0);
        go(0, 0, ha(5, {2'b01, 27'h4}), 2'h2);
        chk(r_err, 1'b1, "io with no io");
        sw(0, 4'h3, 0);
        chk(rd, 32'd0, "chans all mem");
        sw(1, 4'h1, 32'h3f);
    endtask : t_split
    task automatic t_chan();
        sw(1, 4'h0, {3'h0, 18'h2abcd, 1'b1, 10'd5});
        sw(0, 4'h0, 0);
        chk(rd[9:0], 10'd5, "built chan");
        sw(0, 4'h7, 0);
        chk(rd, 32'h0, "unmapped after build");
        go(1, 0, {10'd5, 22'h12345}, 2'h2);
        chk({r_err, r_addr}, {1'b0, 18'h2abcd, 22'h12345}, "phys addr");
        go(1, 0, {10'd6, 22'h0}, 2'h2);
        chk(r_err, 1'b1, "unbuilt");
        sw(1, 4'h0, {3'h0, 18'h00001, 1'b0, 10'd7});
        go(1, 0, {10'd7, 22'h0}, 2'h2);
        chk(r_err, 1'b1, "logical mode");
        go(1, 0, {10'd1008, 22'h0}, 2'h2);
        chk(r_err, 1'b1, "reserved");
        sw(1, 4'h0, {3'h0, 18'h00011, 1'b1, 10'd6});
        go(1, 0, {10'd6, 22'h0}, 2'h2);
        chk({r_err, r_addr}, {1'b0, 18'h00011, 22'h0}, "chained");
        go(1, 1, {10'h3ff, 22'h000100}, 2'h2);
        chk(r_err, 1'b0, "ctx sram");
        go(1, 0, {10'h3ff, 22'h020000}, 2'h2);
        chk(r_err, 1'b0, "shared sram");
        go(1, 0, {10'h3ff, 22'h040000}, 2'h2);
        chk(r_err, 1'b1, "beyond sram");
    endtask : t_chan
    task automatic t_line();
        n_flush = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            u_m_go    <= 1'b1;
            u_m_wr    <= 1'b1;
            u_m_addr  <= {10'd5, 17'h0, i[2:0], 2'b00};
            u_m_wdata <= 32'h11110000 + i;
        end
        @(posedge ref_clk);
        u_m_go <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(n_flush, 1, "flushes");
        chk({flush_line[255:224], flush_line[31:0]}, 64'h11110007_11110000, "line");
        // Nine refused requests so far, line buffer empty after its flush
        sw(0, 4'h2, 0);
        chk(rd, 32'h00090000, "status");
    endtask : t_line
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_split();
        t_cfg();
        t_chan();
        t_line();
        stop_test();
    end
endmodule : pci_host_channel_bridge_test
